// File: bench/cfg_loader.sv
// Purpose: Loader model on the far side
// Assumes: Pins change at falling clk
// Notes: Read clock idles low between frames
`timescale 1ns/1ps
module cfg_loader (
  // Clock
  input wire logic clk,
  // Pins
  input wire serial_rom_pkg::data_pin_t data_pin,
  output logic cclk,
  output logic reset_gate,
  output logic ce_n
);
  initial begin
    cclk = 1'b0;
    reset_gate = 1'b1;
    ce_n = 1'b1;
  end
  // Sample the current bit, then make one rise
  task automatic pulse(input int half, output serial_rom_pkg::data_pin_t got);
    @(negedge clk);
    got = data_pin;
    cclk = 1'b1;
    repeat (half) @(negedge clk);
    cclk = 1'b0;
    repeat (half) @(negedge clk);
  endtask : pulse
  task automatic ctl(input logic gate, input logic sel_n);
    @(negedge clk);
    reset_gate = gate;
    ce_n = sel_n;
    repeat (4) @(negedge clk);
  endtask : ctl
endmodule : cfg_loader

// File: bench/rom_asserts.sv
// Purpose: Port checker for the serial memory reader
// Assumes: Gate polarity and image given by bind
// Notes: Bound after the module
`timescale 1ns/1ps
module rom_asserts #(
  parameter int DEPTH = 16,
  parameter logic [DEPTH-1:0] CONTENTS = '0,
  parameter logic RESET_ACTIVE_HIGH = 1'b1
) (
  // Clock
  input wire logic clk,
  input wire logic rstn,
  // Pins
  input wire logic cclk,
  input wire logic reset_gate,
  input wire logic ce_n,
  input wire serial_rom_pkg::data_pin_t data_pin,
  input wire logic standby,
  input wire logic terminal_count
);
  logic cclk_q;
  int cnt_q;
  wire gate = reset_gate == RESET_ACTIVE_HIGH;
  wire en = !ce_n && !gate;
  wire rise = en && cclk && !cclk_q;
  wire oe = data_pin.dout_oe;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) cclk_q <= 1'b0;
    else cclk_q <= cclk;
  end
  // Taken rises since the last clear, capped past the end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) cnt_q <= 0;
    else if (!en) cnt_q <= 0;
    else if (rise && cnt_q < DEPTH) cnt_q <= cnt_q + 1;
  end
  AST_OFF: assert property (!en [*3] |-> !oe) else $error("oe");
  AST_GATE: assert property (gate [*3] |-> !oe && !terminal_count) else $error("gate");
  AST_SEL: assert property (ce_n [*2] |-> standby && !oe) else $error("sel");
  AST_TCF: assert property (terminal_count |-> !oe) else $error("tcf");
  AST_TCH: assert property ($past(en) && en && terminal_count |=> terminal_count)
    else $error("tch");
  AST_TCA: assert property (rise && cnt_q == DEPTH - 1 |=> ##[0:1] terminal_count)
    else $error("tca");
  AST_BIT: assert property (rise && cnt_q < DEPTH - 1 ##1 en |=> oe &&
    data_pin.dout == CONTENTS[$past(cnt_q, 2) + 1]) else $error("bit");
  AST_ZERO: assert property ($rose(oe) && cnt_q == 0 |->
    data_pin.dout == CONTENTS[0]) else $error("zero");
endmodule : rom_asserts
bind serial_rom_reader rom_asserts #(.DEPTH(DEPTH), .CONTENTS(CONTENTS),
  .RESET_ACTIVE_HIGH(RESET_ACTIVE_HIGH)) chk_u (.clk(clk), .rstn(rstn), .cclk(cclk),
  .reset_gate(reset_gate), .ce_n(ce_n), .data_pin(data_pin), .standby(standby),
  .terminal_count(terminal_count));

// File: bench/testbench.sv
// Purpose: Self-checking bench for the reader
// Assumes: Gate active high on dut_u, active low on a twin, 16-bit image
// Notes: Loader drives all control pins
`timescale 1ns/1ps
module testbench;
  localparam int DEPTH = 16;
  localparam logic [DEPTH-1:0] IMAGE = 16'ha5c3;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic cclk, reset_gate, ce_n, standby, terminal_count;
  serial_rom_pkg::data_pin_t data_pin, got, pin_lo;
  serial_rom_pkg::rd_state_t state;
  int bad_count = 0;
  int checked = 0;
  always #2.5 clk = ~clk;
  serial_rom_reader #(.DEPTH(DEPTH), .CONTENTS(IMAGE)) dut_u (.clk(clk), .rstn(rstn),
    .cclk(cclk), .reset_gate(reset_gate), .ce_n(ce_n), .data_pin(data_pin),
    .standby(standby), .terminal_count(terminal_count), .state(state));
  // Twin with the recommended active-low gate sees the inverted gate line
  serial_rom_reader #(.DEPTH(DEPTH), .CONTENTS(IMAGE), .RESET_ACTIVE_HIGH(1'b0)) dut_lo_u (
    .clk(clk), .rstn(rstn), .cclk(cclk), .reset_gate(~reset_gate), .ce_n(ce_n),
    .data_pin(pin_lo), .standby(), .terminal_count(), .state());
  cfg_loader ldr_u (.clk(clk), .data_pin(data_pin), .cclk(cclk), .reset_gate(reset_gate),
    .ce_n(ce_n));
  task automatic chk(input string what, input logic [1:0] exp, input logic [1:0] seen);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s exp %b seen %b", what, exp, seen);
    end
  endtask : chk
  // Prompt and slow pulses alternate
  task automatic run(input int n);
    for (int i = 0; i < n; i++) begin
      chk("bit lo", {IMAGE[i], 1'b1}, pin_lo);
      ldr_u.pulse(2 + 3 * (i % 2), got);
      chk("bit", {IMAGE[i], 1'b1}, got);
    end
  endtask : run
  task automatic t_full;
    ldr_u.ctl(1'b0, 1'b0);
    run(DEPTH);
    for (int k = 0; k < 2; k++) begin
      ldr_u.pulse(2, got);
      chk("tc", 2'b10, {terminal_count, got.dout_oe});
    end
    chk("done state", serial_rom_pkg::ST_DONE, state);
    ldr_u.ctl(1'b0, 1'b1);
    $display("full done");
  endtask : t_full
  task automatic t_gate;
    ldr_u.ctl(1'b0, 1'b0);
    run(5);
    ldr_u.ctl(1'b1, 1'b0);
    ldr_u.pulse(3, got);
    chk("gated", 2'b00, {terminal_count, got.dout_oe});
    chk("gated lo", 2'b00, {1'b0, pin_lo.dout_oe});
    chk("held state", serial_rom_pkg::ST_HELD, state);
    ldr_u.ctl(1'b0, 1'b0);
    run(3);
    $display("gate done");
  endtask : t_gate
  task automatic t_sel;
    ldr_u.ctl(1'b0, 1'b1);
    ldr_u.pulse(3, got);
    chk("standby", 2'b10, {standby, got.dout_oe});
    chk("standby state", serial_rom_pkg::ST_STANDBY, state);
    ldr_u.ctl(1'b0, 1'b0);
    chk("awake", 2'b00, {1'b0, standby});
    chk("read state", serial_rom_pkg::ST_READ, state);
    run(DEPTH);
    $display("sel done");
  endtask : t_sel
  task automatic complete_run;
    $display("checked %0d bad %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : complete_run
  initial begin
    repeat (20) @(negedge clk);
    rstn = 1'b1;
    t_full();
    t_gate();
    t_sel();
    complete_run();
  end
endmodule : testbench

// File: rtl/bit_fifo.sv
// Purpose: Small valid/ready FIFO
// Assumes: Depth is a power of two
// Notes: Full and empty come from an occupancy count
`timescale 1ns/1ps
module bit_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  input wire logic flush,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;
  assign in_ready = (cnt_q != DEPTH[AW:0]);
  assign out_valid = (cnt_q != '0);
  assign out_data = mem[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else if (flush) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : bit_fifo

// File: rtl/serial_rom_defines.svh
// Purpose: Constants for the serial configuration memory reader
// Assumes: Single clock clk at 200 MHz, active-low async reset rstn
// Notes: Types live in the package; numbers live here
// Operation
// - Count up on rising read clock when enabled
// - Present current bit shortly after each edge
// - Float data when select inactive or gate active
// - Reset input holds counter zero, data floats
// - One-time polarity setting for reset input
// - Select high clears counter, floats, enters standby
// - Contents read-only, never altered by reads
// - Past terminal count stop and float output
`ifndef SERIAL_ROM_DEFINES_SVH
`define SERIAL_ROM_DEFINES_SVH
`define ROM_DEPTH_DEF 1024
`define FIFO_DEPTH_DEF 16
`define POL_ACTIVE_HIGH 1'h1
`define READ_CLK_IDLE 1'h0
`define STANDBY_RESET 1'h1
`endif

// File: rtl/serial_rom_pkg.sv
// Purpose: Types for the serial configuration memory reader
// Assumes: Included defines supply numeric constants
// Notes: Packed structs carry pin groups
package serial_rom_pkg;
  typedef struct packed {
    logic dout;
    logic dout_oe;
  } data_pin_t;
  typedef enum logic [1:0] {
    ST_STANDBY = 2'b00,
    ST_HELD = 2'b01,
    ST_READ = 2'b10,
    ST_DONE = 2'b11
  } rd_state_t;
endpackage : serial_rom_pkg

// File: rtl/serial_rom_reader.sv
// Purpose: Read side of a one-time-programmable serial configuration memory
// Assumes: Read clock arrives as a synchronous level input, sampled on clk
// Notes: Bits prefetch into a FIFO; one bit pops per counted rising edge
`timescale 1ns/1ps
`include "serial_rom_defines.svh"
module serial_rom_reader #(
  parameter int DEPTH = `ROM_DEPTH_DEF,
  parameter int FIFO_DEPTH = `FIFO_DEPTH_DEF,
  parameter logic [DEPTH-1:0] CONTENTS = '0,
  parameter logic RESET_ACTIVE_HIGH = `POL_ACTIVE_HIGH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Control pins from the loader
  input wire logic cclk,
  input wire logic reset_gate,
  input wire logic ce_n,
  // Serial data pin
  output serial_rom_pkg::data_pin_t data_pin,
  // Status
  output logic standby,
  output logic terminal_count,
  output serial_rom_pkg::rd_state_t state
);
  localparam int AW = $clog2(DEPTH) + 1;
  localparam int IW = AW - 1;
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

  // Read-only store: no write path exists
  logic [DEPTH-1:0] rom;
  assign rom = CONTENTS;

  // Pin decode
  logic cclk_q;
  logic rise;
  logic rst_act;
  logic enabled;
  logic flush;
  logic take;

  // Address and prefetch
  logic [AW-1:0] addr_q;
  logic [AW-1:0] fetch_q;
  logic past_tc_q;
  logic lag_q;

  // FIFO handshake
  logic f_in_valid;
  logic f_in_ready;
  logic f_in_data;
  logic f_out_valid;
  logic f_out_ready;
  logic f_out_data;

  // Next values of the registered outputs
  serial_rom_pkg::rd_state_t st_d;
  logic oe_d;
  logic dout_d;

  // Polarity is fixed per part, as a programmed fuse would be
  function automatic logic gate_active(input logic pin);
    return pin == RESET_ACTIVE_HIGH;
  endfunction : gate_active

  function automatic logic is_last(input logic [AW-1:0] ptr);
    return ptr == LAST;
  endfunction : is_last

  function automatic logic in_image(input logic [AW-1:0] ptr);
    return ptr <= LAST;
  endfunction : in_image

  // Shared by the pin address and the prefetch pointer
  function automatic logic [AW-1:0] step(input logic [AW-1:0] ptr);
    return ptr + AW'(1);
  endfunction : step

  function automatic serial_rom_pkg::rd_state_t pick_state(
    input logic sel_n,
    input logic held,
    input logic done
  );
    serial_rom_pkg::rd_state_t st;
    if (sel_n) begin
      st = serial_rom_pkg::ST_STANDBY;
    end else if (held) begin
      st = serial_rom_pkg::ST_HELD;
    end else if (done) begin
      st = serial_rom_pkg::ST_DONE;
    end else begin
      st = serial_rom_pkg::ST_READ;
    end
    return st;
  endfunction : pick_state

  assign rst_act = gate_active(reset_gate);
  assign flush = ce_n || rst_act;
  assign enabled = !flush;
  assign rise = cclk && !cclk_q;
  assign take = enabled && rise && !past_tc_q;

  // Idle level matches a loader that parks its clock low, so no false rise follows reset
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cclk_q <= `READ_CLK_IDLE;
    end else begin
      cclk_q <= cclk;
    end
  end

  // Address of the bit shown on the pin
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      addr_q <= '0;
    end else if (flush) begin
      addr_q <= '0;
    end else if (take && !is_last(addr_q)) begin
      addr_q <= step(addr_q);
    end
  end

  // The counted edge at the last address ends the image
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      past_tc_q <= 1'h0;
    end else if (flush) begin
      past_tc_q <= 1'h0;
    end else if (take && is_last(addr_q)) begin
      past_tc_q <= 1'h1;
    end
  end

  // A rise taken before the head is valid would shift every later bit by one;
  // the pin floats until the next clear rather than send a wrong image
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lag_q <= 1'h0;
    end else if (flush) begin
      lag_q <= 1'h0;
    end else if (take && !f_out_valid) begin
      lag_q <= 1'h1;
    end
  end

  // Prefetch pointer keeps the FIFO ahead of the pin
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      fetch_q <= '0;
    end else if (flush) begin
      fetch_q <= '0;
    end else if (f_in_valid && f_in_ready) begin
      fetch_q <= step(fetch_q);
    end
  end
  assign f_in_valid = enabled && in_image(fetch_q);
  assign f_in_data = rom[fetch_q[IW-1:0]];
  assign f_out_ready = take;

  bit_fifo #(
    .WIDTH(1),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rstn(rstn),
    .flush(flush),
    .in_valid(f_in_valid),
    .in_ready(f_in_ready),
    .in_data(f_in_data),
    .out_valid(f_out_valid),
    .out_ready(f_out_ready),
    .out_data(f_out_data)
  );

  always_comb begin
    st_d = pick_state(ce_n, rst_act, past_tc_q);
  end

  always_comb begin
    oe_d = 1'h0;
    case (st_d)
      serial_rom_pkg::ST_READ: oe_d = f_out_valid && !lag_q;
      serial_rom_pkg::ST_DONE: oe_d = 1'h0;
      default: oe_d = 1'h0;
    endcase
  end
  // An empty FIFO parks the bit low rather than show unwritten storage
  assign dout_d = f_out_valid && f_out_data;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= serial_rom_pkg::ST_STANDBY;
    end else begin
      state <= st_d;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      standby <= `STANDBY_RESET;
    end else begin
      standby <= ce_n;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      terminal_count <= 1'h0;
    end else begin
      terminal_count <= past_tc_q;
    end
  end

  // Bit and its enable move together, so the pin never drives a stale value
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      data_pin <= '0;
    end else begin
      data_pin.dout <= dout_d;
      data_pin.dout_oe <= oe_d;
    end
  end
endmodule : serial_rom_reader
